// ---- hw/sar_ctl_pkg.sv ----
// Shared constants of the successive-approximation converter control block
package sar_ctl_pkg;
  localparam int RESULT_W         = 10;
  localparam int LEVEL_W          = 8;
  localparam int NIB_W            = 4;
  localparam int CTRL_W           = 4;
  // Converter control fields
  localparam int MODE_BIT         = 3;
  localparam int CHAN_MSB         = 2;
  localparam int CHAN_W           = 3;
  localparam logic [2:0] CHAN_MAX = 3'h5;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [7:0] LEVEL_RESET  = 8'h00;
  // Interrupt control bit cleared before leaving comparator mode
  localparam int IRQ_CMP_BIT      = 2;
  // Operation lengths in machine cycles
  localparam int CONVERT_CYCLES   = 62;
  localparam int COMPARE_CYCLES   = 8;
  localparam int CNT_W            = 6;
  // Machine cycle in ns and divider derived from the 100 MHz clock
  localparam int MCLK_NS          = 10;
  localparam int MACHINE_NS       = 500;
  localparam int MACHINE_DIV      = MACHINE_NS / MCLK_NS;
endpackage

// ---- hw/sar_adc_comparator_control.sv ----
// Control logic of a 10-bit successive-approximation converter/comparator
// Behaviour
// RULE1 - Result is 10 bits; high fetch gives upper eight bits in B and A.
// RULE2 - Low fetch puts result bits 1:0 into A bits 3:2, zeroes A 1:0.
// RULE3 - Software never fetches a result while conversion runs.
// RULE4 - During conversion DAC code equals the result register.
// RULE5 - Completion flag is set to one when conversion finishes.
// RULE6 - Flag clears on interrupt taken or on a skip that found it set.
// RULE7 - Skip-if-done tests the flag; interrupt control picks irq or skip.
// RULE8 - Start begins conversion; result lands without further software.
// RULE9 - Each conversion first clears the whole result register; code loads 10'h200 at start, MSB trial already set.
// RULE10 - Each bit MSB first: set, compare, keep when reference below input.
// RULE11 - Conversion ends 62 machine cycles after start, raising irq and flag.
// RULE12 - Mode bit one selects comparator mode.
// RULE13 - Comparator threshold drives DAC; load takes B high nibble, A low.
// RULE14 - Entering comparator mode leaves the result undefined.
// RULE15 - Threshold kept across modes, accessible only in comparator mode.
// RULE16 - In comparator mode DAC reference is VDD/256 times threshold.
// RULE17 - In comparator mode flag is one when input is below reference.
// RULE18 - Comparator start ends 8 machine cycles later, then updates flag.
// RULE19 - Software never changes mode while an operation runs.
// RULE20 - Software clears interrupt control bit 2 before leaving comparator.
// RULE21 - Flag may set on comparator-to-conversion switch; software skips.
// RULE22 - Mode bit zero selects conversion mode.
// RULE23 - Control bits 2:0 pick inputs 0 to 5; codes 6 and 7 unavailable.
// RULE24 - Start while running restarts from the clear, count begins again.
`timescale 1ns/1ps
module sar_adc_comparator_control #(
  parameter int MACHINE_DIV    = sar_ctl_pkg::MACHINE_DIV,
  parameter int CONVERT_CYCLES = sar_ctl_pkg::CONVERT_CYCLES,
  parameter int COMPARE_CYCLES = sar_ctl_pkg::COMPARE_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Core instruction strobes, one mclk cycle each
  input  wire logic       convertStartOp,
  input  wire logic       skipIfDoneOp,
  input  wire logic       fetchResultHighOp,
  input  wire logic       fetchResultLowOp,
  input  wire logic       setThresholdOp,
  input  wire logic       ctrlWrite,
  input  wire logic       interruptTaken,
  // Core work registers and interrupt control
  input  wire logic [3:0] regA,
  input  wire logic [3:0] regB,
  input  wire logic       irqSelect,
  // Results back to the core
  output logic      [3:0] nextRegA,
  output logic      [3:0] nextRegB,
  output logic            regAWrite,
  output logic            regBWrite,
  output logic            skipTaken,
  output logic      [3:0] converterControl,
  output logic            irqRequest,
  output logic            doneFlag,
  output logic            busy,
  // Analog side
  input  wire logic       compareHigh,
  output logic      [9:0] dacCode,
  output logic            dacTenBit,
  output logic      [2:0] inputSelect,
  output logic            analogEnable
);

  typedef enum logic [2:0] {
    IDLE    = 3'b001,
    CONVERT = 3'b010,
    COMPARE = 3'b100
  } state_t;

  state_t     state;
  state_t     next_state;
  logic [9:0] result;
  logic [9:0] next_result;
  logic [7:0] level;
  logic [7:0] next_level;
  logic [3:0] next_converterControl;
  logic       next_doneFlag;
  logic       next_irqRequest;
  logic [5:0] cycleCnt;
  logic [5:0] next_cycleCnt;
  logic [3:0] bitIdx;
  logic [3:0] next_bitIdx;
  logic [6:0] divCnt;
  logic [6:0] next_divCnt;
  logic       divWrap;
  logic       tick;
  logic       compSync1;
  logic       compSync2;
  logic       modeCmp;
  logic       convertLast;
  logic       compareLast;
  logic       finish;

  assign modeCmp = converterControl[sar_ctl_pkg::MODE_BIT];

  // Machine-cycle enable from the system clock; a start realigns the
  // divider so every operation counts whole machine cycles
  assign divWrap = (divCnt == 7'(MACHINE_DIV - 1));

  always_comb
  begin
    next_divCnt = divCnt + 7'h01;
    if (sys_rst || convertStartOp || divWrap)
      next_divCnt = 7'h00;
  end

  always_ff @(posedge mclk)
  begin
    divCnt <= next_divCnt;
  end

  assign tick = divWrap;

  // The comparator output is asynchronous to mclk; only the second
  // stage is read, the first may still be settling
  always_ff @(posedge mclk)
  begin
    compSync1 <= compareHigh;
    compSync2 <= compSync1;
  end

  // One-bit-per-machine-cycle SAR step; spare cycles hold the last trial
  function automatic logic [9:0] sar_step(input logic [9:0] cur,
                                          input logic [3:0] idx,
                                          input logic       keep);
    logic [9:0] v;
    v = cur;
    v[idx] = keep;
    if (idx != 4'h0)
      v[idx - 4'h1] = 1'b1;
    return v;
  endfunction

  // Last machine cycle of each operation
  assign convertLast = (state == CONVERT) && tick &&
                       (cycleCnt == 6'(CONVERT_CYCLES - 1));
  assign compareLast = (state == COMPARE) && tick &&
                       (cycleCnt == 6'(COMPARE_CYCLES - 1));
  assign finish      = convertLast || compareLast;

  // Control and threshold registers
  always_comb
  begin
    next_converterControl = converterControl;
    next_level            = level;
    if (ctrlWrite)
      next_converterControl = regA; // RULE12 RULE22 RULE23
    // The threshold is writable in comparator mode only
    if (setThresholdOp && modeCmp)
      next_level = {regB, regA}; // RULE13 RULE15
    if (sys_rst)
    begin
      next_converterControl = sar_ctl_pkg::CTRL_RESET;
      next_level            = sar_ctl_pkg::LEVEL_RESET;
    end
  end

  always_ff @(posedge mclk)
  begin
    converterControl <= next_converterControl;
    level            <= next_level;
  end

  // Sequencer, result register and machine-cycle count
  always_comb
  begin
    next_state    = state;
    next_result   = result;
    next_cycleCnt = cycleCnt;
    next_bitIdx   = bitIdx;
    // Entering comparator mode leaves a fixed pattern, not the old result
    if (ctrlWrite && !modeCmp && regA[sar_ctl_pkg::MODE_BIT])
      next_result = 10'h3ff; // RULE14
    unique case (state)
      IDLE:
      begin
      end
      CONVERT:
      begin
        if (tick)
        begin
          next_cycleCnt = cycleCnt + 6'h01;
          if (bitIdx != 4'hf)
          begin
            // Keep the trial bit while the reference sits below the input
            next_result = sar_step(result, bitIdx, compSync2); // RULE10
            next_bitIdx = (bitIdx == 4'h0) ? 4'hf : bitIdx - 4'h1;
          end
        end
      end
      COMPARE:
      begin
        if (tick)
          next_cycleCnt = cycleCnt + 6'h01;
      end
    endcase
    if (finish)
      next_state = IDLE; // RULE8 RULE11 RULE18
    // A start wins over a finish, so a running operation begins again
    if (convertStartOp)
    begin
      next_cycleCnt = 6'h00; // RULE24
      if (modeCmp)
        next_state = COMPARE; // RULE18
      else
      begin
        next_state  = CONVERT;
        next_result = 10'h200; // RULE9
        next_bitIdx = 4'h9;
      end
    end
    if (sys_rst)
    begin
      next_state    = IDLE;
      next_result   = sar_ctl_pkg::RESULT_RESET;
      next_cycleCnt = 6'h00;
      next_bitIdx   = 4'hf;
    end
  end

  always_ff @(posedge mclk)
  begin
    state    <= next_state;
    result   <= next_result;
    cycleCnt <= next_cycleCnt;
    bitIdx   <= next_bitIdx;
  end

  // Completion flag and interrupt pulse
  always_comb
  begin
    next_doneFlag   = doneFlag;
    next_irqRequest = 1'b0;
    // Clear first so that a finish in the same cycle still writes the flag;
    // the same skip also clears a flag left by a mode change
    if (interruptTaken || (skipIfDoneOp && doneFlag))
      next_doneFlag = 1'b0; // RULE6 RULE7 RULE21
    if (convertLast)
    begin
      next_doneFlag   = 1'b1; // RULE5 RULE11 RULE8
      next_irqRequest = irqSelect;
    end
    else if (compareLast)
    begin
      // Input below reference means the comparator reads low
      next_doneFlag   = !compSync2; // RULE17 RULE18
      next_irqRequest = irqSelect && !compSync2;
    end
    if (sys_rst)
    begin
      next_doneFlag   = 1'b0;
      next_irqRequest = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    doneFlag   <= next_doneFlag;
    irqRequest <= next_irqRequest;
  end

  // Fetches are combinational answers in the instruction's own cycle;
  // a fetch during a conversion returns the partial result
  always_comb
  begin
    nextRegA  = regA;
    nextRegB  = regB;
    regAWrite = 1'b0;
    regBWrite = 1'b0;
    if (fetchResultHighOp)
    begin
      nextRegB  = result[9:6]; // RULE1
      nextRegA  = result[5:2];
      regAWrite = 1'b1;
      regBWrite = 1'b1;
    end
    else if (fetchResultLowOp)
    begin
      nextRegA  = {result[1:0], 2'h0}; // RULE2
      regAWrite = 1'b1;
    end
    else if (setThresholdOp && !modeCmp)
    begin
      // Threshold is invisible outside comparator mode
      regAWrite = 1'b0; // RULE15
    end
  end

  assign skipTaken    = skipIfDoneOp && doneFlag; // RULE7
  assign busy         = (state != IDLE);
  assign dacTenBit    = !modeCmp;
  assign dacCode      = modeCmp ? {level, 2'h0} : result; // RULE4 RULE16
  assign inputSelect  = converterControl[sar_ctl_pkg::CHAN_MSB:0];
  // Unavailable channel codes keep the analog switch open
  assign analogEnable = busy &&
                        (inputSelect <= sar_ctl_pkg::CHAN_MAX); // RULE23

endmodule

// ---- bench/sar_adc_comparator_control_checker.sv ----
// Port assertions for the converter control block
`timescale 1ns/1ps
module sar_adc_comparator_control_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Core side
  input wire logic       convertStartOp,
  input wire logic       skipIfDoneOp,
  input wire logic       fetchResultHighOp,
  input wire logic       fetchResultLowOp,
  input wire logic [3:0] nextRegA,
  input wire logic [3:0] nextRegB,
  input wire logic       regAWrite,
  input wire logic       skipTaken,
  input wire logic [3:0] converterControl,
  input wire logic       doneFlag,
  input wire logic       busy,
  // Analog side
  input wire logic [9:0] dacCode,
  input wire logic       dacTenBit,
  input wire logic [2:0] inputSelect
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Fetch checks hold only when idle in conversion mode
  wire logic cv = !converterControl[3] && !busy;
  property p_skip; skipTaken == (skipIfDoneOp && doneFlag); endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_clr; skipTaken && !busy |=> !doneFlag; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_go;
    convertStartOp |=> busy && (converterControl[3] || dacCode == 10'h200);
  endproperty
  a_go: assert property (p_go) else $error("start");
  property p_dac; dacTenBit == !converterControl[3]; endproperty
  a_dac: assert property (p_dac) else $error("mode");
  property p_sel; inputSelect == converterControl[2:0]; endproperty
  a_sel: assert property (p_sel) else $error("input");
  property p_lo;
    fetchResultLowOp && cv |-> regAWrite && nextRegA == {dacCode[1:0], 2'h0};
  endproperty
  a_lo: assert property (p_lo) else $error("low");
  property p_hi;
    fetchResultHighOp && cv |-> {nextRegB, nextRegA} == dacCode[9:2];
  endproperty
  a_hi: assert property (p_hi) else $error("high");
  property p_end;
    $fell(busy) && !$past(sys_rst) && !converterControl[3] |-> doneFlag;
  endproperty
  a_end: assert property (p_end) else $error("done");
  c_conv: cover property ($fell(busy) && !converterControl[3]);
  c_cmp: cover property ($fell(busy) && converterControl[3]);
  c_skip: cover property (skipTaken);
endmodule
bind sar_adc_comparator_control sar_adc_comparator_control_checker u_chk (.*);

// ---- bench/sar_analog_model.sv ----
// Behavioural DAC and comparator on the analog side
`timescale 1ns/1ps
module sar_analog_model (
  // Analog side
  input  wire logic [9:0]  dacCode,
  input  wire logic        analogEnable,
  input  wire logic [10:0] inputLevel,
  output logic             compareHigh
);
  // Threshold codes sit at bits 9:2, so one scale serves both modes
  always_comb
    compareHigh = analogEnable
      && ({1'b0, dacCode} < inputLevel);
endmodule

// ---- bench/sar_adc_comparator_control_tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_comparator_control_tb;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [6:0]  ops = 7'h00;
  logic [3:0]  regA = 4'h0;
  logic [3:0]  regB = 4'h0;
  logic        irqSelect = 1'b0;
  logic [10:0] input_voltage = 11'h000;
  logic [31:0] rng = 32'h00006b49;
  logic [3:0]  nextRegA, nextRegB, converterControl;
  logic [9:0]  dacCode, r;
  logic [7:0]  lvl;
  logic [2:0]  inputSelect;
  logic        regAWrite, regBWrite, skipTaken, irqRequest, doneFlag;
  logic        busy, compareHigh, dacTenBit, analogEnable, irq;
  int          err_total = 0;
  int          total_checks = 0;
  int          n;
  always #5 mclk = ~mclk;
  sar_adc_comparator_control #(.MACHINE_DIV(4)) dut (
    .convertStartOp(ops[0]), .skipIfDoneOp(ops[1]),
    .fetchResultHighOp(ops[2]), .fetchResultLowOp(ops[3]),
    .setThresholdOp(ops[4]), .ctrlWrite(ops[5]), .interruptTaken(ops[6]),
    .*);
  sar_analog_model far (.inputLevel(input_voltage), .*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // A bit stays only when the trial is strictly below the input
  function automatic logic [9:0] sar_exp(input logic [10:0] v);
    return (v == 11'h000) ? 10'h000 : 10'(v - 11'h001);
  endfunction
  task automatic ck(input string w, input logic [9:0] e, s);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One strobe per cycle; k of 7 leaves the cycle idle
  task automatic op(input int k, input logic [3:0] a = 4'h0, b = 4'h0);
    @(posedge mclk);
    ops <= 7'(1 << k);
    regA <= a;
    regB <= b;
    #1;
  endtask
  task automatic run(input int lo, hi);
    op(0);
    op(7);
    ck("enable", 10'h001, 10'(analogEnable));
    n = 1;
    irq = 1'b0;
    while (busy === 1'b1 && n < 400)
    begin
      @(posedge mclk);
      #1;
      irq = irq | irqRequest;
      n++;
    end
    ck("length", 10'h001, 10'(n >= lo && n <= hi));
  endtask
  initial
  begin
    #100us;
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    op(7);
    ck("reset", 10'h000, {doneFlag, busy, converterControl});
    for (int i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      input_voltage <= (i == 0) ? 11'h000 : (i == 1) ? 11'h400 : {1'b0, rng[9:0]};
      irqSelect <= rng[12];
      op(5, 4'(i));
      run(245, 252);
      r = sar_exp(input_voltage);
      ck("irq", 10'(irqSelect), 10'(irq));
      ck("done", 10'h001, 10'(doneFlag));
      op(1);
      ck("skip", 10'h001, 10'(skipTaken));
      op(3);
      ck("low", 10'({r[1:0], 2'h0}), 10'(nextRegA));
      op(2);
      ck("high", 10'(r[9:2]), 10'({nextRegB, nextRegA}));
      ck("write", 10'h003, 10'({regAWrite, regBWrite}));
      op(7);
      ck("clear", 10'h000, 10'(doneFlag));
    end
    op(0);
    repeat (20) op(7);
    run(245, 252);
    op(1);
    op(5, 4'h8);
    for (int j = 0; j < 2; j++)
    begin
      rng = xs(rng);
      lvl = {1'b0, rng[6:0]} + 8'h20;
      op(4, lvl[3:0], lvl[7:4]);
      op(7);
      ck("level", {lvl, 2'h0}, dacCode);
      input_voltage <= {1'b0, lvl, 2'h0} + (j == 0 ? 11'h7fa : 11'h006);
      run(29, 36);
      ck("outcome", 10'(j == 0), 10'(doneFlag));
      op(6);
      op(7);
      ck("taken", 10'h000, 10'(doneFlag));
    end
    irqSelect <= 1'b0;
    op(5, 4'h0);
    op(1);
    op(4, ~lvl[3:0], ~lvl[7:4]);
    op(5, 4'h8);
    op(7);
    ck("kept", {lvl, 2'h0}, dacCode);
    stop_test();
  end
endmodule
